// ===== bench/oic_cpu_model.sv
/* Behavioural CPU core that ends one instruction per request.
 * Assumes the bench pulses go for one cycle and waits for insn_done. */
module oic_cpu_model (
	input wire logic sys_clk, // Bus clock
	input wire logic go, // Finish one instruction
	input wire logic [1:0] kind, // 0 plain, 1 soft trap, 2 illegal
	input wire logic [3:0] lag, // Extra cycles, for a slow core
	output logic insn_done, // Instruction end pulse
	output logic soft_trap, // Soft trap qualifier
	output logic illegal_op // Illegal qualifier
);
	// ****
	// Instruction ends
	// ****
	initial begin
		insn_done = 1'h0;
		soft_trap = 1'h0;
		illegal_op = 1'h0;
	end
	always @(posedge sys_clk) begin
		if (go) begin
			repeat (lag) @(posedge sys_clk);
			insn_done <= 1'h1;
			soft_trap <= kind == 2'h1;
			illegal_op <= kind == 2'h2;
			@(posedge sys_clk);
			insn_done <= 1'h0;
			soft_trap <= 1'h0;
			illegal_op <= 1'h0;
		end
	end
endmodule

// ===== bench/oic_ctrl_chk.sv
/* Port assertions for the option register and interrupt front end.
 * Assumes it is bound into oic_ctrl with the same parameter values. */
module oic_ctrl_chk #(
	parameter int STOP_DELAY = 4064,
	parameter int WD_BASE = 32768
) (
	input wire logic sys_clk, // Bus clock
	input wire logic resetn, // Reset, low
	input wire logic [15:0] reg_addr, // Address
	input wire logic reg_rd, // Read strobe
	input wire logic [7:0] reg_rdata, // Read data
	input wire logic insn_done, // Instruction end
	input wire logic soft_trap, // Soft trap
	input wire logic illegal_op, // Illegal opcode
	input wire logic i_clear, // Clear I
	input wire logic x_clear, // Clear X
	input wire logic rti_restore, // Flag restore
	input wire logic wake, // Stop wake-up
	input wire logic adc_power_up, // Converter power
	input wire logic charge_pump_clock_select, // Pump clock
	input wire logic rc_osc_enable, // RC oscillators
	input wire logic x_flag, // X flag
	input wire logic i_flag, // I flag
	input wire logic int_take, // Accept pulse
	input wire logic [15:0] int_vector, // Vector
	input wire logic resume // Resume pulse
);
	// ****
	// Checks
	// ****
	localparam int RES_MAX = STOP_DELAY + 2;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	sequence s_trap_end;
		insn_done && illegal_op;
	endsequence
	sequence s_quiet_end;
		insn_done && i_flag && x_flag && !soft_trap && !illegal_op && !i_clear && !x_clear
			&& !rti_restore;
	endsequence
	sequence s_nmi_take;
		int_take && int_vector == 16'hfff4;
	endsequence
	chk_take_after_end: assert property (int_take |-> $past(insn_done))
		else $error("accept without an instruction end");
	chk_take_sets_i: assert property (int_take |-> i_flag)
		else $error("accept left I clear");
	chk_trap_vector: assert property (s_trap_end |=> int_take && int_vector == 16'hfff8)
		else $error("illegal opcode not taken");
	chk_masked_quiet: assert property (s_quiet_end |=> !int_take)
		else $error("accept while fully masked");
	chk_nmi_sets_x: assert property (s_nmi_take |-> x_flag && i_flag)
		else $error("pin accept left a flag clear");
	chk_x_no_soft: assert property ($rose(x_flag) |-> s_nmi_take or $past(rti_restore))
		else $error("X set without cause");
	chk_bit2_zero: assert property (reg_rdata[2] == 1'b0)
		else $error("unimplemented bit read as one");
	chk_live_bits: assert property ($past(reg_rd) && $past(reg_addr) == 16'h1039
		|-> reg_rdata[7] == adc_power_up && reg_rdata[6] == charge_pump_clock_select)
		else $error("read data disagrees with live bits");
	chk_rc_follows: assert property (rc_osc_enable == charge_pump_clock_select)
		else $error("oscillator enable differs from select");
	// Wait span kept in a counter, since the full stop delay is far beyond a delay range
	int wake_age;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wake_age <= 0;
		end else if (resume) begin
			wake_age <= 0;
		end else if (wake || wake_age != 0) begin
			wake_age <= wake_age + 1;
		end
	end
	chk_resume_bound: assert property (wake_age <= RES_MAX)
		else $error("no resume after wake");
endmodule

bind oic_ctrl oic_ctrl_chk #(.STOP_DELAY(STOP_DELAY), .WD_BASE(WD_BASE)) u_oic_ctrl_chk (
	.sys_clk, .resetn, .reg_addr, .reg_rd, .reg_rdata, .insn_done, .soft_trap, .illegal_op,
	.i_clear, .x_clear, .rti_restore, .wake, .adc_power_up, .charge_pump_clock_select,
	.rc_osc_enable, .x_flag, .i_flag, .int_take, .int_vector, .resume);

// ===== bench/tb_option_reg_and_interrupt_vectors.sv
/* Self-checking bench for oic_ctrl with a behavioural CPU core.
 * Assumes shortened stop and watchdog counts of 8 and 16. */
module tb_option_reg_and_interrupt_vectors import oic_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Bench
	// ****
	localparam int SD = 8;
	localparam int WD = 16;
	logic sys_clk, resetn, reg_wr, reg_rd, test_mode, irq_pin_n, pseudo_nmi_pin_n, go;
	logic i_clear, x_clear, stop_enter, wake, clk_slow, watchdog_disable_cfg, watchdog_service;
	logic [15:0] reg_addr, int_vector, reset_vector;
	logic [7:0] reg_wdata, reg_rdata;
	logic [3:0] promote_sel, lag;
	logic [1:0] kind;
	oic_src_s src_req, src_en;
	logic adc_power_up, charge_pump_clock_select, rc_osc_enable, x_flag, i_flag, int_take;
	logic resume, reset_req, insn_done, soft_trap, illegal_op;
	int n_errors = 0;
	int checked = 0;

	oic_ctrl #(.STOP_DELAY(SD), .WD_BASE(WD)) u_oic_ctrl (.sys_clk, .resetn, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .test_mode, .irq_pin_n, .pseudo_nmi_pin_n,
		.src_req, .src_en, .promote_sel, .insn_done, .soft_trap, .illegal_op, .i_set(1'h0),
		.i_clear, .x_clear, .rti_restore(1'h0), .rti_xi(2'h0), .stop_enter, .wake, .clk_slow,
		.watchdog_disable_cfg, .watchdog_service, .adc_power_up, .charge_pump_clock_select,
		.rc_osc_enable, .x_flag, .i_flag, .int_take, .int_vector, .resume, .reset_req,
		.reset_vector);
	oic_cpu_model u_oic_cpu_model (.sys_clk, .go, .kind, .lag, .insn_done, .soft_trap,
		.illegal_op);

	initial begin
		sys_clk = 1'h0;
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Which: 0 instruction end, 1 resume, 2 reset request
	task automatic count_to(input int w, output int n);
		logic s;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
			s = w == 0 ? insn_done : (w == 1 ? resume : reset_req);
		end while (s !== 1'h1 && n < 100);
	endtask
	task automatic wr(input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= 16'h1039;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		@(negedge sys_clk);
		d = reg_rdata;
	endtask
	task automatic rchk(input logic [7:0] exp);
		logic [7:0] d;
		rd(16'h1039, d);
		check(d, exp);
	endtask
	task automatic clr_i();
		@(posedge sys_clk);
		i_clear <= 1'h1;
		@(posedge sys_clk);
		i_clear <= 1'h0;
	endtask
	// Finish one instruction and judge the accept that follows it
	task automatic step(input logic [1:0] k, input logic [3:0] lg, input logic tk,
		input logic [15:0] v);
		int n;
		@(posedge sys_clk);
		go <= 1'h1;
		kind <= k;
		lag <= lg;
		@(posedge sys_clk);
		go <= 1'h0;
		count_to(0, n);
		@(negedge sys_clk);
		check(int_take, tk);
		if (tk) check(int_vector, v);
	endtask
	task automatic do_reset();
		@(posedge sys_clk);
		resetn <= 1'h0;
		repeat (12) @(posedge sys_clk);
		resetn <= 1'h1;
	endtask

	task automatic t_option();
		logic [7:0] d;
		rchk(8'h10);
		wr(8'hff);
		rchk(8'hfb);
		check(rc_osc_enable, 1'h1);
		check({adc_power_up, charge_pump_clock_select}, 2'h3);
		wr(8'h00);
		rchk(8'h33);
		rd(16'h103a, d);
		check(d, 8'h00);
		do_reset();
		repeat (70) @(posedge sys_clk);
		wr(8'hff);
		rchk(8'hd8);
		wr(8'h00);
	endtask
	task automatic t_irq();
		@(posedge sys_clk);
		irq_pin_n <= 1'h0;
		step(2'h0, 4'h0, 1'h0, 16'h0000);
		clr_i();
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		check(int_take, 1'h0);
		step(2'h0, 4'h3, 1'h1, 16'hfff2);
		check(i_flag, 1'h1);
	endtask
	task automatic t_edge();
		@(posedge sys_clk);
		irq_pin_n <= 1'h1;
		test_mode <= 1'h1;
		wr(8'h23);
		rchk(8'h23);
		wr(8'h20);
		rchk(8'h20);
		@(posedge sys_clk);
		irq_pin_n <= 1'h0;
		clr_i();
		step(2'h0, 4'h0, 1'h1, 16'hfff2);
		clr_i();
		step(2'h0, 4'h0, 1'h0, 16'h0000);
		@(posedge sys_clk);
		irq_pin_n <= 1'h1;
		test_mode <= 1'h0;
	endtask
	// Each source alone: refused with its enable off, then taken at its vector
	task automatic t_vectors();
		for (int b = 0; b < 19; b++) begin
			@(posedge sys_clk);
			src_req <= oic_src_s'(19'h1 << b);
			clr_i();
			step(2'h0, 4'h0, 1'h0, 16'h0000);
			@(posedge sys_clk);
			// Overrun shares the receive enable, one bit above it
			src_en <= oic_src_s'((19'h1 << b) | (b == 17 ? 19'h40000 : 19'h0));
			step(2'h0, 4'(b % 3), 1'h1, 16'hfff2 - 16'(2 * (b > 14 ? 14 : b)));
			@(posedge sys_clk);
			src_en <= '0;
		end
	endtask
	task automatic t_prio();
		@(posedge sys_clk);
		src_req <= oic_src_s'(19'h402);
		src_en <= oic_src_s'(19'h402);
		clr_i();
		step(2'h0, 4'h0, 1'h1, 16'hfff0);
		@(posedge sys_clk);
		promote_sel <= 4'h0;
		clr_i();
		step(2'h0, 4'h0, 1'h1, 16'hffde);
		step(2'h1, 4'h0, 1'h1, 16'hfff6);
		step(2'h2, 4'h0, 1'h1, 16'hfff8);
		@(posedge sys_clk);
		x_clear <= 1'h1;
		pseudo_nmi_pin_n <= 1'h0;
		@(posedge sys_clk);
		x_clear <= 1'h0;
		step(2'h0, 4'h0, 1'h1, 16'hfff4);
		check(x_flag, 1'h1);
		@(posedge sys_clk);
		pseudo_nmi_pin_n <= 1'h1;
		promote_sel <= 4'hf;
		src_req <= '0;
		src_en <= '0;
	endtask
	task automatic t_stop(input logic hold);
		int n;
		@(posedge sys_clk);
		test_mode <= 1'h1;
		wr({3'h0, hold, 4'h0});
		@(posedge sys_clk);
		stop_enter <= 1'h1;
		@(posedge sys_clk);
		stop_enter <= 1'h0;
		wake <= 1'h1;
		@(posedge sys_clk);
		wake <= 1'h0;
		count_to(1, n);
		check(16'(n), hold ? 16'(SD + 1) : 16'h1);
		@(posedge sys_clk);
		test_mode <= 1'h0;
	endtask
	task automatic t_resets();
		int n;
		@(posedge sys_clk);
		clk_slow <= 1'h1;
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		check(reset_req, 1'h0);
		wr(8'h08);
		count_to(2, n);
		check(reset_vector, 16'hfffc);
		@(posedge sys_clk);
		clk_slow <= 1'h0;
		wr(8'h00);
		// The count ran on while disabled, so restart it before enabling
		@(posedge sys_clk);
		watchdog_service <= 1'h1;
		@(posedge sys_clk);
		watchdog_service <= 1'h0;
		watchdog_disable_cfg <= 1'h0;
		count_to(2, n);
		check(n >= WD - 3 && n <= WD + 3, 1'h1);
		check(reset_vector, 16'hfffa);
		@(posedge sys_clk);
		watchdog_disable_cfg <= 1'h1;
	endtask

	task automatic end_of_test();
		$display("Errors %0d, comparisons %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		#3000000;
		n_errors++;
		end_of_test();
	end
	initial begin
		{resetn, reg_wr, reg_rd, test_mode, go, i_clear, x_clear} = '0;
		{stop_enter, wake, clk_slow, watchdog_service} = '0;
		{irq_pin_n, pseudo_nmi_pin_n, watchdog_disable_cfg} = 3'h7;
		{reg_addr, reg_wdata, lag, kind} = '0;
		promote_sel = 4'hf;
		src_req = '0;
		src_en = '0;
		do_reset();
		t_option();
		t_irq();
		t_edge();
		t_vectors();
		t_prio();
		t_stop(1'h1);
		t_stop(1'h0);
		t_resets();
		end_of_test();
	end
endmodule

// ===== hdl/oic_ctrl.sv
/*
 * Option register and interrupt front end: option fields (edge, stop-wait and watchdog rate write-once),
 * external pin sensing, priority resolution at instruction ends, vector
 * selection, mask flag upkeep, stop-exit delay and watchdog timeout.
 * Assumes the CPU pulses insn_done at the end of every instruction and
 * fetches the two-byte vector given with int_take.
 */
// The address-and-strobe port is this design's own decision.
`include "oic_defs.svh"

module oic_ctrl import oic_pkg::*; #(
	parameter int STOP_DELAY = `OIC_STOP_DELAY,
	parameter int WD_BASE = `OIC_WD_BASE
) (
	input wire logic sys_clk, // Bus clock
	input wire logic resetn, // Async reset, low
	input wire logic [15:0] reg_addr, // Register address
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [7:0] reg_rdata, // Read data, cycle after strobe
	input wire logic test_mode, // Special test mode
	input wire logic irq_pin_n, // External maskable pin
	input wire logic pseudo_nmi_pin_n, // Pseudo NMI pin
	input wire oic_src_s src_req, // Peripheral flags
	input wire oic_src_s src_en, // Peripheral enables
	input wire logic [3:0] promote_sel, // Priority promotion code
	input wire logic insn_done, // Instruction completed
	input wire logic soft_trap, // Soft trap instruction ends
	input wire logic illegal_op, // Illegal opcode seen
	input wire logic i_set, // Set I flag
	input wire logic i_clear, // Clear I flag
	input wire logic x_clear, // Clear X flag
	input wire logic rti_restore, // Restore flags on return
	input wire logic [1:0] rti_xi, // Restored X and I
	input wire logic stop_enter, // Stop period begins
	input wire logic wake, // Wake-up from stop
	input wire logic clk_slow, // Clock monitor detect
	input wire logic watchdog_disable_cfg, // Watchdog off
	input wire logic watchdog_service, // Watchdog serviced
	output logic adc_power_up, // Converter power
	output logic charge_pump_clock_select, // Pump clock select
	output logic rc_osc_enable, // RC oscillators on
	output logic x_flag, // X mask flag
	output logic i_flag, // I mask flag
	output logic int_take, // Interrupt accepted
	output logic [15:0] int_vector, // Vector address
	output logic resume, // Resume after stop
	output logic reset_req, // Reset request
	output logic [15:0] reset_vector // Vector for that reset
);
	// ************
	// Option register
	// ************
	logic [7:0] opt_r;
	logic [6:0] lock_cnt_r;
	logic locked_r;
	logic opt_hit;
	logic prot_ok;

	assign opt_hit = reg_addr == `OIC_OPT_ADDR;
	assign prot_ok = test_mode | ~locked_r;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			lock_cnt_r <= 7'h00;
		end else if (lock_cnt_r != `OIC_LOCK_CYCLES) begin
			lock_cnt_r <= lock_cnt_r + 7'h01;
		end
	end

	// Locks on first write or when the window expires untouched
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			locked_r <= 1'b0;
		end else if (reg_wr && opt_hit) begin
			locked_r <= 1'b1;
		end else if (lock_cnt_r == `OIC_LOCK_CYCLES - 7'h01) begin
			locked_r <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			opt_r <= `OIC_OPT_RESET;
		end else if (reg_wr && opt_hit) begin
			opt_r[`OIC_B_ADC_PWR] <= reg_wdata[`OIC_B_ADC_PWR];
			opt_r[`OIC_B_CPSEL] <= reg_wdata[`OIC_B_CPSEL];
			opt_r[`OIC_B_CLK_MON] <= reg_wdata[`OIC_B_CLK_MON];
			if (prot_ok) begin
				opt_r[`OIC_B_EDGE] <= reg_wdata[`OIC_B_EDGE];
				opt_r[`OIC_B_STOP_WAIT] <= reg_wdata[`OIC_B_STOP_WAIT];
				opt_r[`OIC_B_WDHI] <= reg_wdata[`OIC_B_WDHI];
				opt_r[`OIC_B_WDLO] <= reg_wdata[`OIC_B_WDLO];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd && opt_hit) begin
			reg_rdata <= opt_r & 8'hfb;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// Converter settling time is left to software
	assign adc_power_up = opt_r[`OIC_B_ADC_PWR];
	assign charge_pump_clock_select = opt_r[`OIC_B_CPSEL];
	assign rc_osc_enable = opt_r[`OIC_B_CPSEL];

	// ************
	// External pin sensing
	// ************
	logic irq_prev_r;
	logic irq_edge_r;
	logic pnmi_prev_r;
	logic pnmi_edge_r;
	logic irq_pin_req;
	logic take_irq;
	logic take_pnmi;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			irq_prev_r <= 1'b1;
			pnmi_prev_r <= 1'b1;
		end else begin
			irq_prev_r <= irq_pin_n;
			pnmi_prev_r <= pseudo_nmi_pin_n;
		end
	end

	// A new edge in the cycle of acceptance wins over the clear
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			irq_edge_r <= 1'b0;
		end else if (irq_prev_r && !irq_pin_n) begin
			irq_edge_r <= 1'b1;
		end else if (take_irq || !opt_r[`OIC_B_EDGE]) begin
			irq_edge_r <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pnmi_edge_r <= 1'b0;
		end else if (pnmi_prev_r && !pseudo_nmi_pin_n) begin
			pnmi_edge_r <= 1'b1;
		end else if (take_pnmi || pseudo_nmi_pin_n) begin
			pnmi_edge_r <= 1'b0;
		end
	end

	assign irq_pin_req = opt_r[`OIC_B_EDGE] ? irq_edge_r : ~irq_pin_n;

	// ************
	// Source gating
	// ************
	// Index 0 is highest fixed priority in the I group
	localparam int NSRC = 15;
	logic [NSRC-1:0] req_v;
	logic [15:0] vec_tab [NSRC];
	logic ser_req;

	assign ser_req = (src_req.ser_rx_full & src_en.ser_rx_full)
		| (src_req.ser_overrun & src_en.ser_rx_full)
		| (src_req.ser_idle & src_en.ser_idle)
		| (src_req.ser_tx_empty & src_en.ser_tx_empty)
		| (src_req.ser_tx_done & src_en.ser_tx_done);

	assign req_v[0] = irq_pin_req | (src_req.handshake & src_en.handshake);
	assign req_v[1] = src_req.tick & src_en.tick;
	assign req_v[14] = ser_req;
	assign req_v[13] = src_req.spi_done & src_en.spi_done;
	assign req_v[12] = src_req.pulse_edge & src_en.pulse_edge;
	assign req_v[11] = src_req.pulse_ovf & src_en.pulse_ovf;
	assign req_v[10] = src_req.timer_ovf & src_en.timer_ovf;

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_cap
			// Capture 1 sits at index 2
			assign req_v[2+g] = src_req.in_cap[g] & src_en.in_cap[g];
			assign vec_tab[2+g] = `OIC_VEC_RTI - 16'(2 * (g + 1));
		end
		for (g = 0; g < 5; g++) begin : g_cmp
			// Compare 1 sits at index 5
			assign req_v[5+g] = src_req.out_cmp[g] & src_en.out_cmp[g];
			assign vec_tab[5+g] = `OIC_VEC_IC3 - 16'(2 * (g + 1));
		end
	endgenerate

	assign vec_tab[0] = `OIC_VEC_IRQ;
	assign vec_tab[1] = `OIC_VEC_RTI;
	assign vec_tab[10] = `OIC_VEC_TOF;
	assign vec_tab[11] = `OIC_VEC_PAOV;
	assign vec_tab[12] = `OIC_VEC_PAI;
	assign vec_tab[13] = `OIC_VEC_SPI;
	assign vec_tab[14] = `OIC_VEC_ASER;

	// ************
	// Priority resolution
	// ************
	logic x_r;
	logic i_r;
	logic [4:0] prom_idx;
	logic i_hit;
	logic [3:0] i_idx;
	logic take;
	logic [15:0] vec_nxt;

	always_comb begin
		unique case (promote_sel)
			4'h0: prom_idx = 5'd10;
			4'h1: prom_idx = 5'd11;
			4'h2: prom_idx = 5'd12;
			4'h3: prom_idx = 5'd13;
			4'h4: prom_idx = 5'd14;
			default: prom_idx = 5'd15;
		endcase
	end

	always_comb begin
		i_hit = 1'b0;
		i_idx = 4'h0;
		for (int k = NSRC - 1; k >= 0; k--) begin
			if (req_v[k]) begin
				i_hit = 1'b1;
				i_idx = 4'(k);
			end
		end
		if (prom_idx != 5'd15 && req_v[prom_idx[3:0]]) begin
			i_idx = prom_idx[3:0];
		end
	end

	// Everything is judged only at the instruction end
	always_comb begin
		take = 1'b0;
		take_pnmi = 1'b0;
		take_irq = 1'b0;
		vec_nxt = `OIC_VEC_RST;
		if (insn_done) begin
			if (illegal_op) begin
				take = 1'b1;
				vec_nxt = `OIC_VEC_ILL;
			end else if (soft_trap) begin
				take = 1'b1;
				vec_nxt = `OIC_VEC_TRAP;
			end else if (pnmi_edge_r && !x_r) begin
				take = 1'b1;
				take_pnmi = 1'b1;
				vec_nxt = `OIC_VEC_PNMI;
			end else if (i_hit && !i_r) begin
				take = 1'b1;
				take_irq = i_idx == 4'h0;
				vec_nxt = vec_tab[i_idx];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			int_take <= 1'b0;
			int_vector <= `OIC_VEC_RST;
		end else begin
			int_take <= take;
			if (take) begin
				int_vector <= vec_nxt;
			end
		end
	end

	// ************
	// Mask flags
	// ************
	// Software can only clear X; hardware and a return set it
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			x_r <= 1'b1;
		end else if (take_pnmi) begin
			x_r <= 1'b1;
		end else if (rti_restore) begin
			x_r <= rti_xi[1];
		end else if (x_clear) begin
			x_r <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			i_r <= 1'b1;
		end else if (take) begin
			i_r <= 1'b1;
		end else if (rti_restore) begin
			i_r <= rti_xi[0];
		end else if (i_set) begin
			i_r <= 1'b1;
		end else if (i_clear) begin
			i_r <= 1'b0;
		end
	end

	assign x_flag = x_r;
	assign i_flag = i_r;

	// ************
	// Stop exit delay
	// ************
	oic_stop_e st_r;
	logic [12:0] wait_cnt_r;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= OIC_RUN;
			wait_cnt_r <= 13'h0000;
			resume <= 1'b0;
		end else begin
			resume <= 1'b0;
			unique case (st_r)
				OIC_RUN: begin
					if (stop_enter) begin
						st_r <= OIC_STOP;
					end
				end
				OIC_STOP: begin
					if (wake && opt_r[`OIC_B_STOP_WAIT]) begin
						st_r <= OIC_WAKE;
						wait_cnt_r <= 13'(STOP_DELAY - 1);
					end else if (wake) begin
						st_r <= OIC_RUN;
						resume <= 1'b1;
					end
				end
				OIC_WAKE: begin
					if (wait_cnt_r == 13'h0000) begin
						st_r <= OIC_RUN;
						resume <= 1'b1;
					end else begin
						wait_cnt_r <= wait_cnt_r - 13'h0001;
					end
				end
				default: st_r <= OIC_RUN;
			endcase
		end
	end

	// ************
	// Watchdog and clock monitor
	// ************
	// Service sequence decoding lives elsewhere; a pulse restarts the count
	logic [21:0] wd_cnt_r;
	logic [21:0] wd_lim;
	logic wd_fail;
	logic cm_fail;

	always_comb begin
		unique case (opt_r[`OIC_B_WDHI:`OIC_B_WDLO])
			2'b00: wd_lim = 22'(WD_BASE - 1);
			2'b01: wd_lim = 22'(WD_BASE * 4 - 1);
			2'b10: wd_lim = 22'(WD_BASE * 16 - 1);
			2'b11: wd_lim = 22'(WD_BASE * 64 - 1);
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wd_cnt_r <= 22'h000000;
		end else if (watchdog_service || wd_fail) begin
			wd_cnt_r <= 22'h000000;
		end else begin
			wd_cnt_r <= wd_cnt_r + 22'h000001;
		end
	end

	assign wd_fail = !watchdog_disable_cfg && wd_cnt_r >= wd_lim;
	assign cm_fail = opt_r[`OIC_B_CLK_MON] & clk_slow;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reset_req <= 1'b0;
			reset_vector <= `OIC_VEC_RST;
		end else begin
			reset_req <= cm_fail | wd_fail;
			if (cm_fail) begin
				reset_vector <= `OIC_VEC_CMF;
			end else if (wd_fail) begin
				reset_vector <= `OIC_VEC_WDOG;
			end
		end
	end
endmodule

// ===== hdl/oic_defs.svh
/*
 * Offsets, field positions, reset values, vectors and timing counts of
 * the option register and interrupt front end.
 * Assumes a 10 MHz bus clock and a CPU core that reports instruction ends.
 */
`ifndef OIC_DEFS_SVH
`define OIC_DEFS_SVH
`define OIC_OPT_ADDR 16'h1039
`define OIC_B_ADC_PWR 7
`define OIC_B_CPSEL 6
`define OIC_B_EDGE 5
`define OIC_B_STOP_WAIT 4
`define OIC_B_CLK_MON 3
`define OIC_B_WDHI 1
`define OIC_B_WDLO 0
`define OIC_OPT_RESET 8'h10
`define OIC_LOCK_CYCLES 7'h40
`define OIC_STOP_DELAY 4064
`define OIC_WD_BASE 32768
`define OIC_VEC_ASER 16'hffd6
`define OIC_VEC_SPI 16'hffd8
`define OIC_VEC_PAI 16'hffda
`define OIC_VEC_PAOV 16'hffdc
`define OIC_VEC_TOF 16'hffde
`define OIC_VEC_OC5 16'hffe0
`define OIC_VEC_IC3 16'hffea
`define OIC_VEC_RTI 16'hfff0
`define OIC_VEC_IRQ 16'hfff2
`define OIC_VEC_PNMI 16'hfff4
`define OIC_VEC_TRAP 16'hfff6
`define OIC_VEC_ILL 16'hfff8
`define OIC_VEC_WDOG 16'hfffa
`define OIC_VEC_CMF 16'hfffc
`define OIC_VEC_RST 16'hfffe
`endif

// ===== hdl/oic_pkg.sv
/*
 * Types shared by the option register and interrupt front end.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package oic_pkg;
	typedef enum logic [1:0] {
		OIC_RUN = 2'b00,
		OIC_STOP = 2'b01,
		OIC_WAKE = 2'b10
	} oic_stop_e;

	// Local request flags and their enables from on-chip peripherals
	typedef struct packed {
		logic ser_rx_full;
		logic ser_overrun;
		logic ser_idle;
		logic ser_tx_empty;
		logic ser_tx_done;
		logic spi_done;
		logic pulse_edge;
		logic pulse_ovf;
		logic timer_ovf;
		logic [4:0] out_cmp;
		logic [2:0] in_cap;
		logic tick;
		logic handshake;
	} oic_src_s;
endpackage
